// File: logic/txc_defines.svh
`ifndef TXC_DEFINES_SVH
`define TXC_DEFINES_SVH
// register byte offsets
`define TXC_OFF_FRAME 8'h00
`define TXC_OFF_SKIP 8'h04
`define TXC_OFF_SYMLEN 8'h08
`define TXC_OFF_SYM01 8'h0c
`define TXC_OFF_SYM23 8'h10
`define TXC_OFF_AUX 8'h14
`define TXC_OFF_SEED 8'h18
`define TXC_OFF_DATA 8'h1c
`define TXC_OFF_CMD 8'h20
`define TXC_OFF_RCV 8'h38
// tx_frame_control fields
`define TXC_FC_DCODE 0
`define TXC_FC_SOF 4
`define TXC_FC_EOF 6
`define TXC_FC_STRT_EN 8
`define TXC_FC_STRT_VAL 9
`define TXC_FC_STOP_EN 10
`define TXC_FC_STOP_VAL 11
`define TXC_FC_EGT 12
`define TXC_FC_PAR_EN 15
`define TXC_FC_PAR_ODD 16
`define TXC_FC_ENC_EN 17
`define TXC_FC_MSB 18
// symbol length register fields
`define TXC_SL_LO 0
`define TXC_SL_HI 8
`define TXC_SL_BLEN 16
`define TXC_SL_BEN 24
`define TXC_SL_BVAL 25
// aux control, receiver config, command and data fields
`define TXC_AUX_OSEL 0
`define TXC_AUX_DSEL 4
`define TXC_AUX_MFR 6
`define TXC_RCV_SINGLE 0
`define TXC_RCV_ADC 1
`define TXC_RCV_ISEL 2
`define TXC_CMD_START 0
`define TXC_DATA_LAST 8
// reset values and limits
`define TXC_RST_FRAME 19'h00000
`define TXC_RST_SEED 16'hace1
`define TXC_RST_RCV 8'h04
`define TXC_EGT_MAX 3'h6
`define TXC_SKIP_MAX 4'h8
`define TXC_LO_MAX 5'h10
`define TXC_HI_MAX 5'h08
`endif

// File: logic/txc_pkg.sv
`default_nettype none
package txc_pkg;
  typedef enum logic [1:0] {
    TXC_IDLE = 2'b00,
    TXC_SYM = 2'b01,
    TXC_DATA = 2'b10,
    TXC_BURST = 2'b11
  } txc_st_t;

  typedef struct packed {
    logic [18:0] frame;
    logic [3:0] skip;
    logic [25:0] symlen;
    logic [31:0] sym01;
    logic [15:0] sym23;
    logic [6:0] aux;
    logic [15:0] seed;
    logic [7:0] rcv;
    logic [7:0] hold_byte;
    logic hold_last;
    logic hold_full;
    txc_st_t st;
    logic is_eof;
    logic [1:0] cur_sym;
    logic burst_ok;
    logic [15:0] div;
    logic [16:0] shreg;
    logic [16:0] dmask;
    logic [4:0] cnt;
    logic last_byte;
    logic [8:0] burst;
    logic [15:0] lfsr;
    logic env;
    logic strobe;
    logic aux_out;
    logic drive;
    logic rx_data;
    logic [31:0] prdata;
    logic pslverr;
  } txc_state_t;
endpackage
`default_nettype wire

// File: logic/txc_tx_coder.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "txc_defines.svh"

module txc_tx_coder
  import txc_pkg::*;
#(
  parameter int BIT_CYCLES = 8
)
(
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic rx_internal, // internal demodulated receive data
  input wire logic rx_manch_generic, // decoder manchester output
  input wire logic rx_manch_subcarrier, // decoder manchester with subcarrier
  input wire logic aux_signal_in, // auxiliary signal input pin
  output logic aux_signal_out, // auxiliary signal output pin
  output logic tx_envelope, // envelope to modulator
  output logic tx_bit_strobe, // pulse per transmitted bit
  output logic tx_timing_set, // 0: symbol 0/1 timing, 1: symbol 2/3
  output logic tx_active, // frame in progress
  output logic rx_data, // selected receive data
  output logic rx_generic_code, // receive over aux is generic code
  output logic rx_single_ended, // receiver inputs tied single-ended
  output logic mixer_direct_adc, // mixers straight to adc
  output logic multi_frame_receive // multi-frame receive enable
);

  txc_state_t s;
  txc_state_t n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `TXC_OFF_FRAME, `TXC_OFF_SKIP, `TXC_OFF_SYMLEN, `TXC_OFF_SYM01,
      `TXC_OFF_SYM23, `TXC_OFF_AUX, `TXC_OFF_SEED, `TXC_OFF_DATA,
      `TXC_OFF_CMD, `TXC_OFF_RCV: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // {burst allowed, length, pattern} for symbol k
  function automatic logic [21:0] sym_pick(input logic [1:0] k,
                                            input txc_state_t r);
    logic [4:0] len;
    logic [15:0] pat;
    len = 5'h00;
    pat = 16'h0000;
    if (!k[1])
    begin
      len = r.symlen[`TXC_SL_LO +: 5];
      if (len > `TXC_LO_MAX)
        len = `TXC_LO_MAX;
      pat = k[0] ? r.sym01[31:16] : r.sym01[15:0];
    end
    else
    begin
      len = {1'b0, r.symlen[`TXC_SL_HI +: 4]};
      if (len > `TXC_HI_MAX)
        len = `TXC_HI_MAX;
      pat = {8'h00, k[0] ? r.sym23[15:8] : r.sym23[7:0]};
    end
    sym_pick = {!k[1] && r.symlen[`TXC_SL_BEN], len, pat};
  endfunction

  // {length, data mask, bits}, bit 0 sent first
  function automatic logic [38:0] build_byte(input logic [7:0] d,
                                              input logic last,
                                              input txc_state_t r);
    logic [16:0] b;
    logic [16:0] m;
    logic [4:0] k;
    logic [7:0] o;
    logic [3:0] nd;
    logic [3:0] sk;
    logic [2:0] extra_guard_time;
    logic par;
    logic coded;
    b = 17'h00000;
    m = 17'h00000;
    k = 5'h00;
    coded = (r.frame[`TXC_FC_DCODE +: 4] == 4'h0);
    par = r.frame[`TXC_FC_PAR_ODD];
    sk = (r.skip > `TXC_SKIP_MAX) ? `TXC_SKIP_MAX : r.skip;
    nd = last ? 4'h8 - sk : 4'h8;
    extra_guard_time = r.frame[`TXC_FC_EGT +: 3];
    if (extra_guard_time > `TXC_EGT_MAX)
      extra_guard_time = `TXC_EGT_MAX;
    for (int i = 0; i < 8; i++)
      o[i] = r.frame[`TXC_FC_MSB] ? d[7 - i] : d[i];
    if (coded && r.frame[`TXC_FC_STRT_EN])
    begin
      b[k] = r.frame[`TXC_FC_STRT_VAL];
      k = k + 5'h01;
    end
    for (int i = 0; i < 8; i++)
    begin
      if (4'(i) < nd)
      begin
        b[k] = o[i];
        m[k] = coded;
        par = par ^ o[i];
        k = k + 5'h01;
      end
    end
    if (coded && r.frame[`TXC_FC_PAR_EN])
    begin
      b[k] = par;
      k = k + 5'h01;
    end
    if (coded && r.frame[`TXC_FC_STOP_EN])
    begin
      for (int j = 0; j < 7; j++)
      begin
        if (3'(j) <= extra_guard_time)
        begin
          b[k] = r.frame[`TXC_FC_STOP_VAL];
          k = k + 5'h01;
        end
      end
    end
    build_byte = {k, m, b};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic wr;
  logic tick;
  logic bit_now;
  logic [21:0] sp;
  logic [38:0] bb;

  assign wr = psel && penable && pwrite;
  assign tick = (s.div == 16'h0000);

  always_comb
  begin
    n = s;
    bit_now = 1'b0;
    sp = 22'h000000;
    bb = 39'h0;
    n.strobe = 1'b0;
    n.div = tick ? 16'(BIT_CYCLES - 1) : s.div - 16'h0001;
    // register writes
    if (wr)
    begin
      case (paddr)
        `TXC_OFF_FRAME: n.frame = pwdata[18:0];
        `TXC_OFF_SKIP: n.skip = pwdata[3:0];
        `TXC_OFF_SYMLEN: n.symlen = pwdata[25:0];
        `TXC_OFF_SYM01: n.sym01 = pwdata;
        `TXC_OFF_SYM23: n.sym23 = pwdata[15:0];
        `TXC_OFF_AUX: n.aux = pwdata[6:0];
        `TXC_OFF_SEED: n.seed = pwdata[15:0];
        `TXC_OFF_RCV: n.rcv = pwdata[7:0];
        `TXC_OFF_DATA:
        begin
          if (!s.hold_full)
          begin
            n.hold_byte = pwdata[7:0];
            n.hold_last = pwdata[`TXC_DATA_LAST];
            n.hold_full = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // frame sequencer
    case (s.st)
      TXC_IDLE:
      begin
        n.env = 1'b0;
        if (wr && paddr == `TXC_OFF_CMD && pwdata[`TXC_CMD_START])
        begin
          n.lfsr = (s.seed == 16'h0000) ? `TXC_RST_SEED : s.seed;
          n.last_byte = 1'b0;
          n.cnt = 5'h00;
          n.st = TXC_DATA;
          if (s.frame[`TXC_FC_SOF +: 2] != 2'b00)
          begin
            n.cur_sym = s.frame[`TXC_FC_SOF +: 2] - 2'b01;
            sp = sym_pick(n.cur_sym, s);
            if (sp[20:16] != 5'h00)
            begin
              n.st = TXC_SYM;
              n.is_eof = 1'b0;
              n.burst_ok = sp[21];
              n.cnt = sp[20:16];
              n.shreg = {1'b0, sp[15:0]};
            end
          end
        end
      end
      TXC_SYM:
      begin
        if (tick)
        begin
          n.env = s.shreg[s.cnt - 5'h01];
          n.strobe = 1'b1;
          n.cnt = s.cnt - 5'h01;
          if (s.cnt == 5'h01)
          begin
            if (s.burst_ok)
            begin
              n.st = TXC_BURST;
              n.burst = {1'b0, s.symlen[`TXC_SL_BLEN +: 8]} + 9'h001;
            end
            else
              n.st = s.is_eof ? TXC_IDLE : TXC_DATA;
          end
        end
      end
      TXC_BURST:
      begin
        if (tick)
        begin
          n.env = s.symlen[`TXC_SL_BVAL];
          n.strobe = 1'b1;
          n.burst = s.burst - 9'h001;
          if (s.burst == 9'h001)
            n.st = s.is_eof ? TXC_IDLE : TXC_DATA;
        end
      end
      TXC_DATA:
      begin
        if (tick && (s.cnt != 5'h00 || s.hold_full))
        begin
          n.shreg = s.shreg;
          n.dmask = s.dmask;
          n.cnt = s.cnt;
          if (s.cnt == 5'h00)
          begin
            bb = build_byte(s.hold_byte, s.hold_last, s);
            n.shreg = bb[16:0];
            n.dmask = bb[33:17];
            n.cnt = bb[38:34];
            n.last_byte = s.hold_last;
            n.hold_full = 1'b0;
          end
          bit_now = n.shreg[0];
          if (n.dmask[0] && s.frame[`TXC_FC_ENC_EN])
          begin
            bit_now = bit_now ^ s.lfsr[0];
            n.lfsr = {s.lfsr[0] ^ s.lfsr[2] ^ s.lfsr[3] ^ s.lfsr[5],
                      s.lfsr[15:1]};
          end
          n.env = bit_now;
          n.strobe = (n.cnt != 5'h00);
          n.shreg = {1'b0, n.shreg[16:1]};
          n.dmask = {1'b0, n.dmask[16:1]};
          n.cnt = (n.cnt == 5'h00) ? 5'h00 : n.cnt - 5'h01;
        end
        if (n.cnt == 5'h00 && n.last_byte)
        begin
          n.st = TXC_IDLE;
          n.last_byte = 1'b0;
          if (s.frame[`TXC_FC_EOF +: 2] != 2'b00)
          begin
            n.cur_sym = s.frame[`TXC_FC_EOF +: 2];
            sp = sym_pick(n.cur_sym, s);
            if (sp[20:16] != 5'h00)
            begin
              n.st = TXC_SYM;
              n.is_eof = 1'b1;
              n.burst_ok = sp[21];
              n.cnt = sp[20:16];
              n.shreg = {1'b0, sp[15:0]};
            end
          end
        end
      end
      default: n.st = TXC_IDLE;
    endcase
    // signal routing
    case (s.aux[`TXC_AUX_OSEL +: 4])
      4'h1: n.aux_out = s.strobe;
      4'h2: n.aux_out = rx_internal;
      4'h3: n.aux_out = (s.st != TXC_IDLE);
      4'h4: n.aux_out = s.env;
      4'h6: n.aux_out = rx_manch_generic;
      4'h7: n.aux_out = rx_manch_subcarrier;
      default: n.aux_out = 1'b0;
    endcase
    case (s.aux[`TXC_AUX_DSEL +: 2])
      2'b00: n.drive = 1'b0;
      2'b01: n.drive = s.env;
      2'b10: n.drive = aux_signal_in;
      default: n.drive = 1'b1;
    endcase
    case (s.rcv[`TXC_RCV_ISEL +: 2])
      2'b01: n.rx_data = rx_internal;
      2'b10, 2'b11: n.rx_data = aux_signal_in;
      default: n.rx_data = 1'b0;
    endcase
    // apb read data captured in setup, shown in access
    if (psel && !penable)
    begin
      n.pslverr = !mapped(paddr);
      case (paddr)
        `TXC_OFF_FRAME: n.prdata = {13'h0000, s.frame};
        `TXC_OFF_SKIP: n.prdata = {28'h0000000, s.skip};
        `TXC_OFF_SYMLEN: n.prdata = {6'h00, s.symlen};
        `TXC_OFF_SYM01: n.prdata = s.sym01;
        `TXC_OFF_SYM23: n.prdata = {16'h0000, s.sym23};
        `TXC_OFF_AUX: n.prdata = {25'h0000000, s.aux};
        `TXC_OFF_SEED: n.prdata = {16'h0000, s.seed};
        `TXC_OFF_DATA: n.prdata = {23'h000000, s.hold_last, s.hold_byte};
        `TXC_OFF_CMD:
          n.prdata = {26'h0000000, s.cur_sym, s.st, s.hold_full,
                      s.st != TXC_IDLE};
        `TXC_OFF_RCV: n.prdata = {24'h000000, s.rcv};
        default: n.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.frame <= `TXC_RST_FRAME;
      s.seed <= `TXC_RST_SEED;
      s.rcv <= `TXC_RST_RCV;
      s.st <= TXC_IDLE;
    end
    else
      s <= n;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = s.pslverr;
  assign aux_signal_out = s.aux_out;
  assign tx_envelope = s.drive;
  assign tx_bit_strobe = s.strobe;
  assign tx_timing_set = s.cur_sym[1];
  assign tx_active = (s.st != TXC_IDLE);
  assign rx_data = s.rx_data;
  assign rx_generic_code = (s.rcv[`TXC_RCV_ISEL +: 2] == 2'b11);
  assign rx_single_ended = s.rcv[`TXC_RCV_SINGLE];
  assign mixer_direct_adc = s.rcv[`TXC_RCV_ADC];
  assign multi_frame_receive = s.aux[`TXC_AUX_MFR];

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_sof_sym;
    $rose(s.st == TXC_SYM) && !s.is_eof |-> s.cur_sym != 2'b11;
  endproperty
  a_sof_sym: assert property (p_sof_sym) else $error("bad start symbol");

  property p_eof_sym;
    s.st == TXC_SYM && s.is_eof |-> s.cur_sym != 2'b00;
  endproperty
  a_eof_sym: assert property (p_eof_sym) else $error("bad end symbol");

  property p_no_hi_burst;
    s.st == TXC_BURST |-> !s.cur_sym[1] && !tx_timing_set;
  endproperty
  a_no_hi_burst: assert property (p_no_hi_burst) else $error("burst on 2/3");

  property p_sym_len;
    s.st == TXC_SYM |-> s.cnt <= (s.cur_sym[1] ? 5'h08 : 5'h10);
  endproperty
  a_sym_len: assert property (p_sym_len) else $error("symbol too long");

  property p_env_route;
    s.aux[3:0] == 4'h4 |=> aux_signal_out == $past(s.env);
  endproperty
  a_env_route: assert property (p_env_route) else $error("envelope route");

  property p_drv_low;
    s.aux[5:4] == 2'b00 ##1 s.aux[5:4] == 2'b00 |-> !tx_envelope;
  endproperty
  a_drv_low: assert property (p_drv_low) else $error("driver not low");

  property p_drv_ext;
    s.aux[5:4] == 2'b10 |=> tx_envelope == $past(aux_signal_in);
  endproperty
  a_drv_ext: assert property (p_drv_ext) else $error("driver not aux");

  property p_strobe_pace;
    tx_bit_strobe |-> s.div == 16'(BIT_CYCLES - 1);
  endproperty
  a_strobe_pace: assert property (p_strobe_pace) else $error("bit pacing");

  property p_burst_val;
    $past(s.st == TXC_BURST) && tx_bit_strobe |-> s.env == s.symlen[`TXC_SL_BVAL];
  endproperty
  a_burst_val: assert property (p_burst_val) else $error("burst value");

  c_sof: cover property ($rose(s.st == TXC_SYM) && !s.is_eof);
  c_burst: cover property (s.st == TXC_BURST ##1 s.st == TXC_DATA);
  c_eof: cover property (s.st == TXC_SYM && s.is_eof ##1 s.st == TXC_IDLE);
  c_enc: cover property (s.st == TXC_DATA && s.frame[17] && tx_bit_strobe);

endmodule
`default_nettype wire

// File: testbench/txc_frontend_model.sv
`timescale 1ns/1ps
`default_nettype none
module txc_frontend_model (
  input wire logic pclk, // core clock
  input wire logic presetn, // async reset, active low
  input wire logic tx_envelope, // envelope from coder
  input wire logic tx_bit_strobe, // bit pulse from coder
  input wire logic aux_signal_out, // aux pin from coder
  output logic rx_internal, // demodulated receive data
  output logic rx_manch_generic, // generic manchester
  output logic rx_manch_subcarrier, // manchester with subcarrier
  output logic aux_signal_in // aux input pin
);
  logic [7:0] cnt;
  logic seen;
  logic env_q[$];
  logic aux_q[$];
  ////////////////////////////////////////////////////////////////////////////////
  // receive lines change every 8, 16 or 32 cycles, each with its own pattern
  assign rx_internal = cnt[3] ^ cnt[5];
  assign rx_manch_generic = cnt[4];
  assign rx_manch_subcarrier = cnt[3] ^ cnt[4] ^ cnt[6];
  assign aux_signal_in = cnt[5] ^ cnt[7];
  ////////////////////////////////////////////////////////////////////////////////
  // envelope lands one cycle after its strobe
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 8'h00;
      seen <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      seen <= tx_bit_strobe;
      if (seen)
      begin
        env_q.push_back(tx_envelope);
        aux_q.push_back(aux_signal_out);
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_tx_bit_symbol_coding.sv
`timescale 1ns/1ps
`default_nettype none
`include "txc_defines.svh"
module test_tx_bit_symbol_coding;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic rx_internal, rx_manch_generic, rx_manch_subcarrier, aux_signal_in;
  logic aux_signal_out, tx_envelope, tx_bit_strobe, tx_timing_set, tx_active;
  logic rx_data, rx_generic_code, rx_single_ended, mixer_direct_adc, multi_frame_receive;
  int failures, total_checks, cycles;
  logic exp_q[$];
  logic enc_q[$];
  logic [3:0] osel_tab [5] = '{4'h0, 4'h2, 4'h6, 4'h7, 4'h5};
  logic [18:0] frame_tab [5] = '{19'h08dd0, 19'h48770, 19'h000a0, 19'h08d00, 19'h28dd0};
  logic [1:0] dsel, isel;
  logic ea, ee, ed;
  logic [18:0] rnd;

  txc_tx_coder #(.BIT_CYCLES(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_internal(rx_internal),
    .rx_manch_generic(rx_manch_generic), .rx_manch_subcarrier(rx_manch_subcarrier),
    .aux_signal_in(aux_signal_in), .aux_signal_out(aux_signal_out),
    .tx_envelope(tx_envelope), .tx_bit_strobe(tx_bit_strobe), .tx_timing_set(tx_timing_set),
    .tx_active(tx_active), .rx_data(rx_data), .rx_generic_code(rx_generic_code),
    .rx_single_ended(rx_single_ended), .mixer_direct_adc(mixer_direct_adc),
    .multi_frame_receive(multi_frame_receive));
  txc_frontend_model ptn (.pclk(pclk), .presetn(presetn), .tx_envelope(tx_envelope),
    .tx_bit_strobe(tx_bit_strobe), .aux_signal_out(aux_signal_out),
    .rx_internal(rx_internal), .rx_manch_generic(rx_manch_generic),
    .rx_manch_subcarrier(rx_manch_subcarrier), .aux_signal_in(aux_signal_in));

  ////////////////////////////////////////////////////////////////////////////////
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
    chk1("slave error", ex, er);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // expected bit stream of one frame
  task automatic put_sym(input int s, input logic [31:0] s01, input logic [15:0] s23,
    input logic [25:0] sl);
    logic [15:0] pat;
    int n;
    pat = (s == 0) ? s01[15:0] : (s == 1) ? s01[31:16] : (s == 2) ? {8'h0, s23[7:0]} :
      {8'h0, s23[15:8]};
    n = (s < 2) ? int'(sl[4:0]) : int'(sl[11:8]);
    for (int i = n - 1; i >= 0; i--)
    begin
      exp_q.push_back(pat[i]);
      enc_q.push_back(1'b0);
    end
    // a symbol of length zero is skipped with its burst
    if (s < 2 && sl[24] && n > 0)
      for (int i = 0; i <= int'(sl[23:16]); i++)
      begin
        exp_q.push_back(sl[25]);
        enc_q.push_back(1'b0);
      end
  endtask
  task automatic put_byte(input logic [18:0] f, input logic [7:0] b, input logic last,
    input logic [3:0] sk);
    logic q[$];
    logic m[$];
    logic c;
    c = (f[3:0] == 4'h0);
    if (c && f[8])
    begin
      q.push_back(f[9]);
      m.push_back(1'b0);
    end
    for (int i = 0; i < 8; i++)
    begin
      q.push_back(f[18] ? b[7 - i] : b[i]);
      m.push_back(c && f[17]);
    end
    if (c && f[15])
    begin
      q.push_back(f[16] ^ (^b));
      m.push_back(1'b0);
    end
    if (c && f[10])
      for (int i = 0; i <= ((f[14:12] > 3'h6) ? 6 : int'(f[14:12])); i++)
      begin
        q.push_back(f[11]);
        m.push_back(1'b0);
      end
    if (last)
      for (int i = 0; i < int'(sk); i++)
      begin
        void'(q.pop_back());
        void'(m.pop_back());
      end
    exp_q = {exp_q, q};
    enc_q = {enc_q, m};
  endtask
  task automatic frame(input logic [18:0] f, input logic [3:0] sk);
    logic [25:0] sl;
    logic [31:0] s01;
    logic [15:0] s23;
    logic [7:0] b0, b1;
    int flips;
    sl = {1'($urandom), 1'($urandom), 8'($urandom), 4'h0, 4'($urandom_range(8)), 3'h0,
      5'($urandom_range(16))};
    s01 = $urandom;
    s23 = 16'($urandom);
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    exp_q.delete();
    enc_q.delete();
    ptn.env_q.delete();
    ptn.aux_q.delete();
    if (f[5:4] != 2'h0)
      put_sym(int'(f[5:4]) - 1, s01, s23, sl);
    put_byte(f, b0, 1'b0, sk);
    put_byte(f, b1, 1'b1, sk);
    if (f[7:6] != 2'h0)
      put_sym(int'(f[7:6]), s01, s23, sl);
    apb(1'b1, `TXC_OFF_FRAME, {13'h0, f});
    rchk(`TXC_OFF_FRAME, {13'h0, f}, 1'b0, "frame control");
    apb(1'b1, `TXC_OFF_SYMLEN, {6'h0, sl});
    apb(1'b1, `TXC_OFF_SYM01, s01);
    apb(1'b1, `TXC_OFF_SYM23, {16'h0, s23});
    apb(1'b1, `TXC_OFF_SKIP, {28'h0, sk});
    apb(1'b1, `TXC_OFF_AUX, 32'h14);
    apb(1'b1, `TXC_OFF_DATA, {24'h0, b0});
    apb(1'b1, `TXC_OFF_CMD, 32'h1);
    do
      apb(1'b0, `TXC_OFF_CMD, 32'h0);
    while (rd[1] !== 1'b0);
    apb(1'b1, `TXC_OFF_DATA, {23'h0, 1'b1, b1});
    apb(1'b1, `TXC_OFF_CMD, 32'h1);
    while (tx_active !== 1'b0)
      @(posedge pclk);
    repeat (4) @(posedge pclk);
    chk("bit count", 32'(exp_q.size()), 32'(ptn.env_q.size()));
    flips = 0;
    for (int i = 0; i < exp_q.size(); i++)
    begin
      // encrypted data bits: count flips, keystream is not modelled bit by bit
      if (enc_q[i])
      begin
        flips += int'(exp_q[i] !== ptn.env_q[i]);
        chk1("aux out bit", ptn.env_q[i], ptn.aux_q[i]);
      end
      else
      begin
        chk1("envelope bit", exp_q[i], ptn.env_q[i]);
        chk1("aux out bit", exp_q[i], ptn.aux_q[i]);
      end
    end
    if (f[17])
      chk1("keystream applied", 1'b1, flips != 0);
    if (f[7:6] != 2'h0)
      chk1("timing set", f[7], tx_timing_set);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(69));
    rchk(`TXC_OFF_RCV, 32'h04, 1'b0, "receiver config reset");
    rchk(`TXC_OFF_SEED, 32'hace1, 1'b0, "seed reset");
    rchk(8'h3c, 32'h0, 1'b1, "unmapped read");
    apb(1'b1, 8'h3c, 32'hffffffff);
    chk1("unmapped write error", 1'b1, er);
    for (int i = 0; i < 5; i++)
    begin
      dsel = 2'(i % 4);
      isel = 2'((i + 1) % 4);
      apb(1'b1, `TXC_OFF_AUX, {25'h0, i[0], dsel, osel_tab[i]});
      apb(1'b1, `TXC_OFF_RCV, {28'h0, isel, i[1], i[0]});
      rchk(`TXC_OFF_RCV, {28'h0, isel, i[1], i[0]}, 1'b0, "receiver config");
      do
        @(posedge pclk);
      while (ptn.cnt[2:0] !== 3'h4);
      #1;
      ea = (osel_tab[i] == 4'h2) ? rx_internal : (osel_tab[i] == 4'h6) ? rx_manch_generic :
        (osel_tab[i] == 4'h7) ? rx_manch_subcarrier : 1'b0;
      ee = (dsel == 2'h2) ? aux_signal_in : (dsel == 2'h3);
      ed = (isel == 2'h1) ? rx_internal : (isel[1] ? aux_signal_in : 1'b0);
      chk1("aux out", ea, aux_signal_out);
      chk1("envelope source", ee, tx_envelope);
      chk1("rx data", ed, rx_data);
      chk1("generic code", isel == 2'h3, rx_generic_code);
      chk1("single ended", i[0], rx_single_ended);
      chk1("mixer adc", i[1], mixer_direct_adc);
      chk1("multi frame", i[0], multi_frame_receive);
    end
    for (int i = 0; i < 5; i++)
    begin
      rnd = {2'h0, 1'($urandom), 1'b0, 3'($urandom), 12'h000};
      frame(frame_tab[i] | rnd | ((i == 3) ? 19'($urandom_range(15, 1)) : 19'h0),
        (i == 2) ? 4'($urandom_range(8)) : 4'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
